// *** include/pif_pkg.sv ***
package pif_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] FLAGS_ONE_OFFS = 8'h00;
  localparam logic [7:0] FLAGS_TWO_OFFS = 8'h04;
  localparam logic [7:0] ENABLE_OFFS    = 8'h08;
  localparam logic [7:0] MODE_OFFS      = 8'h0c;
  localparam logic [7:0] LEVEL_OFFS     = 8'h10;

  // ==========================================================================
  // field positions in the second flag register, plus the timer overflow bit of the first
  localparam int OSC_FAIL_BIT  = 7;
  localparam int CMP_TWO_BIT   = 6;
  localparam int CMP_ONE_BIT   = 5;
  localparam int NV_WRITE_BIT  = 4;
  localparam int BUS_COLL_BIT  = 3;
  localparam int LP_WAKE_BIT   = 2;
  localparam int UNUSED_BIT    = 1;
  localparam int CAPCOMP_BIT   = 0;
  localparam int T1_OVF_BIT    = 0;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] FLAGS_TWO_IMPL = 8'hfd;
  localparam logic [7:0] FLAGS_ONE_IMPL = 8'h01;
  localparam logic [1:0] MODE_RESET   = 2'h0;

  // ==========================================================================
  // capture/compare unit mode
  typedef enum logic [1:0] {
    CC_OFF     = 2'h0,
    CC_CAPTURE = 2'h1,
    CC_COMPARE = 2'h3,
    CC_PWM     = 2'h2
  } pif_cc_mode_t;

  // ==========================================================================
  // hardware event carrier
  typedef struct packed {
    logic osc_fail;
    logic cmp_two_out;
    logic cmp_one_out;
    logic nv_write_done;
    logic bus_collision;
    logic i2c_master;
    logic lp_wake;
    logic capture_evt;
    logic compare_evt;
    logic t1_overflow;
  } pif_evt_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pif_pkg

// *** src/pif_flags.sv ***
`timescale 1ns/10ps
// Operation
// - timer one overflow sets bit 0, sticky
// - flags set regardless of any enable
// - oscillator failure sets bit 7, sticky
// - comparator two output change sets bit 6
// - comparator one output change sets bit 5
// - completed nonvolatile write sets bit 4
// - i2c master bus collision sets bit 3
// - low power wake condition sets bit 2
// - bit 1 unimplemented, reads zero
// - capture mode capture sets bit 0
// - compare match sets bit 0, pwm unused
module pif_flags
  import pif_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // hardware events, already in the aclk domain
  input  pif_evt_t         evt,
  // interrupt
  output logic             irq
);

  // ==========================================================================
  // state
  logic [7:0]   flags_two_q;
  logic         flags_one_q;
  logic [7:0]   enable_q;
  pif_cc_mode_t mode_q;
  logic         cmp_two_q;
  logic         cmp_one_q;
  logic         aw_hold_q;
  logic         w_hold_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic         wstrb0_q;

  function automatic logic [7:0] word_sel(input logic [7:0] addr);
    word_sel = {addr[7:2], 2'b00};
  endfunction : word_sel

  // ==========================================================================
  // event decode
  // comparator history resets low, so a high input at release flags once
  logic [7:0] set_two;
  logic       set_one;
  always_comb
  begin
    set_two = 8'h00;
    set_two[OSC_FAIL_BIT] = evt.osc_fail;
    set_two[CMP_TWO_BIT]  = evt.cmp_two_out ^ cmp_two_q;
    set_two[CMP_ONE_BIT]  = evt.cmp_one_out ^ cmp_one_q;
    set_two[NV_WRITE_BIT] = evt.nv_write_done;
    set_two[BUS_COLL_BIT] = evt.bus_collision & evt.i2c_master;
    set_two[LP_WAKE_BIT]  = evt.lp_wake;
    set_two[CAPCOMP_BIT]  = ((mode_q == CC_CAPTURE) & evt.capture_evt)
                          | ((mode_q == CC_COMPARE) & evt.compare_evt);
    set_one = evt.t1_overflow;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_two_q <= 1'b0;
      cmp_one_q <= 1'b0;
    end
    else
    begin
      cmp_two_q <= evt.cmp_two_out;
      cmp_one_q <= evt.cmp_one_out;
    end
  end

  // ==========================================================================
  // write channel: address and data in either order
  // one write in flight: readies stay low while a response waits
  logic       do_write;
  logic [7:0] wr_addr;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wr_addr  = word_sel(awaddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr > LEVEL_OFFS) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // flag registers: hardware set beats software clear
  logic wr_lane;
  assign wr_lane = do_write & wstrb0_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_two_q <= FLAGS_RESET;
      flags_one_q <= 1'b0;
    end
    else
    begin
      // enables never gate the set path
      if (wr_lane & (wr_addr == FLAGS_TWO_OFFS))
        flags_two_q <= (wdata_q[7:0] | set_two) & FLAGS_TWO_IMPL;
      else
        flags_two_q <= (flags_two_q | set_two) & FLAGS_TWO_IMPL;
      if (wr_lane & (wr_addr == FLAGS_ONE_OFFS))
        flags_one_q <= wdata_q[T1_OVF_BIT] | set_one;
      else
        flags_one_q <= flags_one_q | set_one;
    end
  end

  // ==========================================================================
  // enable and mode control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_q <= FLAGS_RESET;
      mode_q   <= CC_OFF;
    end
    else if (wr_lane & (wr_addr == ENABLE_OFFS))
      enable_q <= wdata_q[7:0];
    else if (wr_lane & (wr_addr == MODE_OFFS))
      mode_q <= pif_cc_mode_t'(wdata_q[1:0]);
  end

  // ==========================================================================
  // interrupt: enable byte bit 1 gates the timer flag (no flag there)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(flags_two_q & enable_q) | (flags_one_q & enable_q[UNUSED_BIT]);
  end

  // ==========================================================================
  // read channel
  logic [7:0] rd_addr;
  assign rd_addr = word_sel(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (rd_addr)
          FLAGS_ONE_OFFS: s_axi_rdata <= {31'h0, flags_one_q};
          FLAGS_TWO_OFFS: s_axi_rdata <= {24'h0, flags_two_q};
          ENABLE_OFFS:    s_axi_rdata <= {24'h0, enable_q};
          MODE_OFFS:      s_axi_rdata <= {30'h0, mode_q};
          LEVEL_OFFS:     s_axi_rdata <= {30'h0, evt.cmp_two_out, evt.cmp_one_out};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  osc_fail_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.osc_fail |=> flags_two_q[OSC_FAIL_BIT])
    else $error("osc fail flag not set");
  cmp_edge_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt.cmp_two_out != cmp_two_q) |=> flags_two_q[CMP_TWO_BIT])
    else $error("comparator two change missed");
  cmp_one_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(evt.cmp_one_out) |=> flags_two_q[CMP_ONE_BIT])
    else $error("comparator one change missed");
  nv_done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.nv_write_done |=> flags_two_q[NV_WRITE_BIT])
    else $error("nv write flag not set");
  bus_coll_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(evt.i2c_master && evt.bus_collision) && !flags_two_q[BUS_COLL_BIT]
      && !(wr_lane && wr_addr == FLAGS_TWO_OFFS) |=> !flags_two_q[BUS_COLL_BIT])
    else $error("bus collision flag set spuriously");
  wake_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.lp_wake |=> flags_two_q[LP_WAKE_BIT])
    else $error("wake flag not set");
  bit_one_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !flags_two_q[UNUSED_BIT])
    else $error("unimplemented bit set");
  capture_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == CC_CAPTURE) && evt.capture_evt |=> flags_two_q[CAPCOMP_BIT])
    else $error("capture flag not set");
  pwm_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == CC_PWM) && !flags_two_q[CAPCOMP_BIT]
      && !(wr_lane && wr_addr == FLAGS_TWO_OFFS) |=> !flags_two_q[CAPCOMP_BIT])
    else $error("capcomp flag set in pwm mode");
  t1_ovf_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_one_q && !(wr_lane && wr_addr == FLAGS_ONE_OFFS) |=> flags_one_q)
    else $error("timer overflow flag lost");
  set_beats_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.lp_wake && wr_lane && wr_addr == FLAGS_TWO_OFFS |=> flags_two_q[LP_WAKE_BIT])
    else $error("clear beat set");
  sw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lane && wr_addr == FLAGS_TWO_OFFS && set_two == 8'h00
      |=> flags_two_q == (wdata_q[7:0] & FLAGS_TWO_IMPL))
    else $error("software write not stored");
  compare_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == CC_COMPARE) && evt.compare_evt |=> flags_two_q[CAPCOMP_BIT])
    else $error("compare flag not set");
  capture_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == CC_COMPARE) && evt.capture_evt && !evt.compare_evt && !flags_two_q[CAPCOMP_BIT]
      && !(wr_lane && wr_addr == FLAGS_TWO_OFFS) |=> !flags_two_q[CAPCOMP_BIT])
    else $error("capture counted outside capture mode");
  bus_coll_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.i2c_master && evt.bus_collision |=> flags_two_q[BUS_COLL_BIT])
    else $error("bus collision flag not set");
  t1_ovf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.t1_overflow |=> flags_one_q)
    else $error("timer overflow flag not set");
  irq_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (flags_two_q == 8'h00) && !flags_one_q |=> !irq)
    else $error("interrupt without a flag");

  wr_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
  rd_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid);
  irq_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  cmp_chg_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) $changed(evt.cmp_two_out));
  capcomp_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_two_q[CAPCOMP_BIT]));

endmodule : pif_flags

// *** testbench/test_pif_flags.sv ***
`timescale 1ns/10ps
module test_pif_flags
  import pif_pkg::*;
();
  // ==========================================================================
  // bench signals
  logic         aclk;
  logic         aresetn;
  logic [7:0]   s_axi_awaddr;
  logic         s_axi_awvalid;
  logic         s_axi_awready;
  logic [31:0]  s_axi_wdata;
  logic [3:0]   s_axi_wstrb;
  logic         s_axi_wvalid;
  logic         s_axi_wready;
  logic [1:0]   s_axi_bresp;
  logic         s_axi_bvalid;
  logic         s_axi_bready;
  logic [7:0]   s_axi_araddr;
  logic         s_axi_arvalid;
  logic         s_axi_arready;
  logic [31:0]  s_axi_rdata;
  logic [1:0]   s_axi_rresp;
  logic         s_axi_rvalid;
  logic         s_axi_rready;
  pif_evt_t     evt;
  logic         irq;
  logic [9:0]   lvl;
  int           failures;
  int           checks_done;
  logic [9:0]   ev_tab [3] = '{10'h200, 10'h040, 10'h008};
  logic [7:0]   ex_tab [3] = '{8'h80, 8'h10, 8'h04};
  logic [9:0]   cv_tab [2] = '{10'h100, 10'h080};
  logic [7:0]   cf_tab [2] = '{8'h40, 8'h20};
  pif_cc_mode_t md_tab [3] = '{CC_CAPTURE, CC_COMPARE, CC_PWM};
  logic [7:0]   mx_tab [3] = '{8'h01, 8'h01, 8'h00};
  logic [9:0]   pv_tab [3] = '{10'h004, 10'h002, 10'h006};

  pif_flags pif_flags_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .evt, .irq);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================================
  // compare and bus tasks
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // waits end on the answer alone; the watchdog bounds a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic       aw_ok;
    logic       w_ok;
    logic       done;
    logic [1:0] taken;
    logic [1:0] seen;
    logic [1:0] resp;
    done = 1'b0;
    taken = 2'b00;
    seen = 2'b00;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    #1;
    while (!done)
    begin
      aw_ok = (s_axi_awvalid === 1'b1) && (s_axi_awready === 1'b1);
      w_ok = (s_axi_wvalid === 1'b1) && (s_axi_wready === 1'b1);
      resp = s_axi_bresp;
      done = (s_axi_bvalid === 1'b1);
      seen = taken;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      taken = taken | {aw_ok, w_ok};
      if (done) s_axi_bready <= 1'b0;
      else #1;
    end
    check_data({30'h0, seen}, 32'h3);
    check_data({30'h0, resp}, {30'h0, er});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ar_ok;
    logic        done;
    logic        taken;
    logic        seen;
    logic [31:0] data;
    logic [1:0]  resp;
    done = 1'b0;
    taken = 1'b0;
    seen = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    #1;
    while (!done)
    begin
      ar_ok = (s_axi_arvalid === 1'b1) && (s_axi_arready === 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      done = (s_axi_rvalid === 1'b1);
      seen = taken;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      taken = taken | ar_ok;
      if (done) s_axi_rready <= 1'b0;
      else #1;
    end
    check_data({31'h0, seen}, 32'h1);
    check_data(data, ed);
    check_data({30'h0, resp}, {30'h0, er});
  endtask : rd_chk

  // level inputs stay at lvl, event bits pulse for one cycle
  task automatic pulse(input logic [9:0] v);
    @(posedge aclk);
    evt <= pif_evt_t'(lvl | v);
    @(posedge aclk);
    evt <= pif_evt_t'(lvl);
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge aclk);
    #1;
    check_bit(irq, e);
  endtask : irq_chk

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    #200000;
    failures++;
    stop_test;
  end

  // ==========================================================================
  // tests
  initial
  begin
    failures = 0;
    checks_done = 0;
    lvl = 10'h000;
    evt = pif_evt_t'(10'h000);
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0, RESP_OKAY);
    irq_chk(1'b0);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      pulse(ev_tab[i]);
      repeat (20) @(posedge aclk);
      rd_chk(FLAGS_TWO_OFFS, {24'h0, ex_tab[i]}, RESP_OKAY);
      wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    end
    pulse(10'h001);
    repeat (20) @(posedge aclk);
    rd_chk(FLAGS_ONE_OFFS, 32'h1, RESP_OKAY);
    rd_chk(FLAGS_TWO_OFFS, 32'h0, RESP_OKAY);
    $display("test events done");
    for (int i = 0; i < 2; i++)
    begin
      lvl = cv_tab[i];
      pulse(10'h000);
      rd_chk(LEVEL_OFFS, 32'(2 - i), RESP_OKAY);
      rd_chk(FLAGS_TWO_OFFS, {24'h0, cf_tab[i]}, RESP_OKAY);
      wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
      lvl = 10'h000;
      pulse(10'h000);
      rd_chk(FLAGS_TWO_OFFS, {24'h0, cf_tab[i]}, RESP_OKAY);
      wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    end
    pulse(10'h020);
    rd_chk(FLAGS_TWO_OFFS, 32'h0, RESP_OKAY);
    lvl = 10'h010;
    pulse(10'h020);
    lvl = 10'h000;
    rd_chk(FLAGS_TWO_OFFS, 32'h08, RESP_OKAY);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      wr(MODE_OFFS, {30'h0, md_tab[i]}, 4'hf, RESP_OKAY);
      pulse(pv_tab[i]);
      rd_chk(FLAGS_TWO_OFFS, {24'h0, mx_tab[i]}, RESP_OKAY);
      wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    end
    $display("test sources done");
    wr(FLAGS_TWO_OFFS, 32'hff, 4'hf, RESP_OKAY);
    rd_chk(FLAGS_TWO_OFFS, 32'hfd, RESP_OKAY);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'h0, RESP_OKAY);
    rd_chk(FLAGS_TWO_OFFS, 32'hfd, RESP_OKAY);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    rd_chk(FLAGS_TWO_OFFS, 32'h0, RESP_OKAY);
    lvl = 10'h008;
    pulse(10'h000);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    lvl = 10'h000;
    pulse(10'h000);
    rd_chk(FLAGS_TWO_OFFS, 32'h04, RESP_OKAY);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    rd_chk(FLAGS_TWO_OFFS, 32'h00, RESP_OKAY);
    wr(8'h14, 32'hff, 4'hf, RESP_SLVERR);
    rd_chk(8'h14, 32'h0, RESP_SLVERR);
    $display("test access done");
    wr(ENABLE_OFFS, 32'h80, 4'hf, RESP_OKAY);
    irq_chk(1'b0);
    pulse(10'h200);
    irq_chk(1'b1);
    wr(ENABLE_OFFS, 32'h00, 4'hf, RESP_OKAY);
    irq_chk(1'b0);
    wr(ENABLE_OFFS, 32'h82, 4'hf, RESP_OKAY);
    irq_chk(1'b1);
    wr(FLAGS_TWO_OFFS, 32'h0, 4'hf, RESP_OKAY);
    irq_chk(1'b1);
    wr(FLAGS_ONE_OFFS, 32'h0, 4'hf, RESP_OKAY);
    irq_chk(1'b0);
    $display("test interrupt done");
    stop_test;
  end
endmodule : test_pif_flags
